// *** inc/rx_status_regs.svh ***
`ifndef RX_STATUS_REGS_SVH
`define RX_STATUS_REGS_SVH

// register byte offsets
`define OFS_CTRL       8'h00
`define OFS_STATUS     8'h04
`define OFS_IRQ_STAT   8'h08
`define OFS_IRQ_EN     8'h0c
`define OFS_IRQ_CLR    8'h10

// control register fields
`define CTRL_FLAG_MODE_SELECT_BIT  0
`define CTRL_LOOPBACK_BIT 1
`define CTRL_EQ_BIT       2
`define CTRL_WIDE_BIT     3
`define CTRL_W            4
`define CTRL_RESET        4'h0

// status register fields
`define STAT_LINK_BIT     0
`define STAT_FILL_BIT     1
`define STAT_FREQ_BIT     2
`define STAT_EQ_BIT       3
`define STAT_W            4

// interrupt status, enable and clear share this layout
`define IRQ_INVALID_BIT   0
`define IRQ_ALT_BIT       1
`define IRQ_LINK_UP_BIT   2
`define IRQ_LINK_DOWN_BIT 3
`define IRQ_W             4
`define IRQ_RESET         4'h0

// word widths
`define DATA_W            20
`define NARROW_W          16

`endif

// *** inc/rx_status_pkg.sv ***
package rx_status_pkg;

  typedef enum logic [2:0] {
    KIND_DATA   = 3'h0,
    KIND_CTRL   = 3'h1,
    KIND_FILL0  = 3'h2,
    KIND_FILL1A = 3'h3,
    KIND_FILL1B = 3'h4
  } frame_kind_e;

  function automatic logic kind_is_fill_one(input logic [2:0] kind);
    return (kind == KIND_FILL1A) || (kind == KIND_FILL1B);
  endfunction

  function automatic logic kind_is_valid(input logic [2:0] kind);
    return (kind == KIND_DATA) || (kind == KIND_CTRL) || (kind == KIND_FILL0) ||
           kind_is_fill_one(kind);
  endfunction

endpackage

// *** inc/frame_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface frame_if;
  logic       stb;
  logic [2:0] kind;
  logic       flag;
  logic       flag_mode;
  logic       err_invalid;
  logic       err_alt;
  logic       is_data;
  logic       is_ctrl;
  logic       is_fill;
  logic       fill_one;

  modport chk (input stb, kind, flag, flag_mode,
               output err_invalid, err_alt, is_data, is_ctrl, is_fill, fill_one);
  modport top (output stb, kind, flag, flag_mode,
               input err_invalid, err_alt, is_data, is_ctrl, is_fill, fill_one);
endinterface
`default_nettype wire

// *** design/frame_check.sv ***
`timescale 1ns/1ps
`default_nettype none
module frame_check
  import rx_status_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic rstn_in,
  frame_if.chk      fr
);

  logic last_flag_q;
  logic seen_q;

  // only data frames advance the history; control and fill frames leave it alone
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      last_flag_q <= 1'b0;
      seen_q      <= 1'b0;
    end else if (fr.stb && fr.kind == KIND_DATA) begin // see [RULE16]
      last_flag_q <= fr.flag;
      seen_q      <= !fr.flag_mode;
    end else if (fr.flag_mode) begin
      // restart the check fresh when alternation mode is entered again
      seen_q      <= 1'b0;
    end
  end

  always_comb begin
    fr.err_invalid = fr.stb && !kind_is_valid(fr.kind); // see [RULE1]
    fr.is_data     = fr.stb && fr.kind == KIND_DATA;
    fr.is_ctrl     = fr.stb && fr.kind == KIND_CTRL;
    fr.is_fill     = fr.stb && kind_is_valid(fr.kind) && fr.kind != KIND_DATA
                     && fr.kind != KIND_CTRL;
    fr.fill_one    = kind_is_fill_one(fr.kind);
    fr.err_alt     = fr.is_data && !fr.flag_mode && seen_q
                     && (fr.flag == last_flag_q); // see [RULE2]
  end

  AST_ALT_BREAK: assert property (@(posedge mclk_in) disable iff (!rstn_in) // see [RULE2]
    (fr.stb && fr.kind == KIND_DATA && !fr.flag_mode && seen_q && fr.flag == last_flag_q)
    |-> fr.err_alt)
    else $error("repeated flag on consecutive data frames not flagged");

  AST_HIST_HOLD: assert property (@(posedge mclk_in) disable iff (!rstn_in) // see [RULE16]
    (fr.stb && fr.kind != KIND_DATA) |=> (last_flag_q == $past(last_flag_q)))
    else $error("non-data frame moved the flag history");

endmodule
`default_nettype wire

// *** design/link_front.sv ***
`timescale 1ns/1ps
`default_nettype none
module link_front (
  input  wire logic mclk_in,
  input  wire logic rstn_in,
  input  wire logic din_in,
  input  wire logic lin_in,
  input  wire logic loopback_enable,
  input  wire logic equalizer_enable,
  input  wire logic freq_detect_disable_in,
  output logic      serial_data_out,
  output logic      equalizer_on_out,
  output logic      freq_detector_on_out,
  output logic      phase_detector_on_out
);

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      serial_data_out <= 1'b0;
    end else begin
      serial_data_out <= loopback_enable ? lin_in : din_in; // see [RULE9]
    end
  end

  // the loopback pair has no equalizer stage, so the enable is masked there
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      equalizer_on_out <= 1'b0;
    end else begin
      equalizer_on_out <= equalizer_enable && !loopback_enable; // see [RULE8] [RULE10]
    end
  end

  // the frequency detector is only for wide lock onto fill frames at startup
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      freq_detector_on_out  <= 1'b1;
      phase_detector_on_out <= 1'b0;
    end else begin
      freq_detector_on_out  <= !freq_detect_disable_in; // see [RULE6]
      phase_detector_on_out <= freq_detect_disable_in;
    end
  end

  AST_LOOP_SEL: assert property (@(posedge mclk_in) disable iff (!rstn_in) // see [RULE9]
    loopback_enable |=> serial_data_out == $past(lin_in))
    else $error("loopback input not selected");

  AST_EQ_MASK: assert property (@(posedge mclk_in) disable iff (!rstn_in) // see [RULE10]
    loopback_enable |=> !equalizer_on_out)
    else $error("equalizer active on loopback path");

  AST_EQ_ON: assert property (@(posedge mclk_in) disable iff (!rstn_in) // see [RULE8]
    (equalizer_enable && !loopback_enable) |=> equalizer_on_out)
    else $error("equalizer not switched on for normal input");

  AST_FREQ_DETECT_DISABLE: assert property (@(posedge mclk_in) disable iff (!rstn_in) // see [RULE6]
    freq_detect_disable_in |=> (phase_detector_on_out && !freq_detector_on_out))
    else $error("frequency detector not replaced by phase detector");

endmodule
`default_nettype wire

// *** design/serial_rx_frame_status.sv ***
// Contract
// [RULE1] error output rises for any frame matching no data, control or fill code.
// [RULE2] with flag mode off, a repeated flag on data frames raises error.
// [RULE3] no data, control or error means fill; fill_kind tells zero from one.
// [RULE4] flag mode on at both ends: flag output is one more data bit.
// [RULE5] flag mode off at both ends: flag output marks even versus odd frames.
// [RULE6] frequency detector disable swaps the frequency detector for a phase detector.
// [RULE7] startup logic must disable the frequency detector before data is sent.
// [RULE8] equalizer enable switches on equalization on the normal serial input.
// [RULE9] loopback enable takes serial data from the loopback pair.
// [RULE10] loopback path has no equalizer; equalizer enable is ignored there.
// [RULE11] link_ready_n is a retimed, inverted copy of the active input.
// [RULE12] link ready low means startup done and indications are valid.
// [RULE13] word width high gives 20-bit words; else 16-bit, upper four undefined.
// [RULE14] all frame outputs settle before the rising recovered frame strobe.
// [RULE15] data_avail_n low marks a data frame; qualify it with link ready.
// [RULE16] control and fill frames leave the flag history alone.
`timescale 1ns/1ps
`default_nettype none
`include "rx_status_regs.svh"
module serial_rx_frame_status
  import rx_status_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        frame_stb_in,
  input  wire logic [2:0]  frame_kind_in,
  input  wire logic [19:0] frame_data_in,
  input  wire logic        frame_flag_in,
  input  wire logic        active_in,
  input  wire logic        freq_detect_disable_in,
  input  wire logic        din_in,
  input  wire logic        lin_in,
  output logic      [19:0] data_out,
  output logic             flag_out,
  output logic             data_avail_n_out,
  output logic             control_avail_out,
  output logic             fill_kind_out,
  output logic             error_out,
  output logic             link_ready_n_out,
  output logic             recovered_frame_strobe_out,
  output logic             serial_data_out,
  output logic             equalizer_on_out,
  output logic             freq_detector_on_out,
  output logic             phase_detector_on_out,
  output logic             irq_out
);

  logic [`CTRL_W-1:0] ctrl_q;
  logic [`IRQ_W-1:0]  irq_stat_q;
  logic [`IRQ_W-1:0]  irq_en_q;
  logic [`IRQ_W-1:0]  irq_set;
  logic [`IRQ_W-1:0]  irq_clr;
  logic               strobe_d1_q;
  logic               flag_mode_select;
  logic               loopback_enable;
  logic               equalizer_enable;
  logic               word_width_select;
  logic               setup_phase;
  logic               access_ok;
  logic               wr_access;
  logic [31:0]        rdata_d;
  logic               addr_hit;

  frame_if fr ();

  assign flag_mode_select  = ctrl_q[`CTRL_FLAG_MODE_SELECT_BIT];
  assign loopback_enable   = ctrl_q[`CTRL_LOOPBACK_BIT];
  assign equalizer_enable  = ctrl_q[`CTRL_EQ_BIT];
  assign word_width_select = ctrl_q[`CTRL_WIDE_BIT];

  assign fr.stb       = frame_stb_in;
  assign fr.kind      = frame_kind_in;
  assign fr.flag      = frame_flag_in;
  assign fr.flag_mode = flag_mode_select;

  frame_check u_check (
    .mclk_in (mclk_in),
    .rstn_in (rstn_in),
    .fr      (fr.chk)
  );

  link_front u_front (
    .mclk_in                (mclk_in),
    .rstn_in                (rstn_in),
    .din_in                 (din_in),
    .lin_in                 (lin_in),
    .loopback_enable        (loopback_enable),
    .equalizer_enable       (equalizer_enable),
    .freq_detect_disable_in (freq_detect_disable_in), // see [RULE7]
    .serial_data_out        (serial_data_out),
    .equalizer_on_out       (equalizer_on_out),
    .freq_detector_on_out   (freq_detector_on_out),
    .phase_detector_on_out  (phase_detector_on_out)
  );

  // ---------------- apb slave, zero wait state ----------------
  assign setup_phase = psel_in && !penable_in;
  assign access_ok   = psel_in && penable_in && pready_out;
  assign wr_access   = access_ok && pwrite_in && !pslverr_out;

  always_comb begin
    rdata_d  = 32'h0000_0000;
    addr_hit = 1'b1;
    unique case (paddr_in)
      `OFS_CTRL:     rdata_d[`CTRL_W-1:0] = ctrl_q;
      `OFS_STATUS: begin
        rdata_d[`STAT_LINK_BIT] = !link_ready_n_out;
        rdata_d[`STAT_FILL_BIT] = fill_kind_out;
        rdata_d[`STAT_FREQ_BIT] = freq_detector_on_out;
        rdata_d[`STAT_EQ_BIT]   = equalizer_on_out;
      end
      `OFS_IRQ_STAT: rdata_d[`IRQ_W-1:0] = irq_stat_q;
      `OFS_IRQ_EN:   rdata_d[`IRQ_W-1:0] = irq_en_q;
      `OFS_IRQ_CLR:  rdata_d = 32'h0000_0000;
      default:       addr_hit = 1'b0;
    endcase
  end

  // answer is prepared in the setup cycle so that every bus output is a flop
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= setup_phase;
      prdata_out  <= (setup_phase && !pwrite_in) ? rdata_d : 32'h0000_0000;
      pslverr_out <= setup_phase && !addr_hit;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      ctrl_q <= `CTRL_RESET;
    end else if (wr_access && paddr_in == `OFS_CTRL) begin
      ctrl_q <= pwdata_in[`CTRL_W-1:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      irq_en_q <= `IRQ_RESET;
    end else if (wr_access && paddr_in == `OFS_IRQ_EN) begin
      irq_en_q <= pwdata_in[`IRQ_W-1:0];
    end
  end

  // ---------------- interrupts ----------------
  always_comb begin
    irq_set                     = '0;
    irq_set[`IRQ_INVALID_BIT]   = fr.err_invalid;
    irq_set[`IRQ_ALT_BIT]       = fr.err_alt;
    irq_set[`IRQ_LINK_UP_BIT]   = frame_stb_in && active_in && link_ready_n_out;
    irq_set[`IRQ_LINK_DOWN_BIT] = frame_stb_in && !active_in && !link_ready_n_out;
    irq_clr = (wr_access && paddr_in == `OFS_IRQ_CLR) ? pwdata_in[`IRQ_W-1:0] : '0;
  end

  // a new event in the clearing cycle survives: set wins over clear
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      irq_stat_q <= `IRQ_RESET;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_en_q);
    end
  end

  // ---------------- frame outputs ----------------
  // outputs change one cycle after the frame strobe, the recovered strobe rises
  // a cycle later, so capture on its rising edge always sees settled values
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      strobe_d1_q                <= 1'b0;
      recovered_frame_strobe_out <= 1'b0;
    end else begin
      strobe_d1_q                <= frame_stb_in;
      recovered_frame_strobe_out <= strobe_d1_q; // see [RULE14]
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      data_avail_n_out  <= 1'b1;
      control_avail_out <= 1'b0;
      error_out         <= 1'b0;
    end else if (frame_stb_in) begin
      // startup can produce false data indications; users gate with link ready
      data_avail_n_out  <= !fr.is_data; // see [RULE15] [RULE12]
      control_avail_out <= fr.is_ctrl;
      error_out         <= fr.err_invalid || fr.err_alt; // see [RULE1] [RULE2]
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      fill_kind_out <= 1'b0;
    end else if (fr.is_fill) begin
      fill_kind_out <= fr.fill_one; // see [RULE3]
    end
  end

  // in flag mode the flag is a plain extra data bit; otherwise it is the
  // even/odd marker of the data frame; control frames carry no flag
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      flag_out <= 1'b0;
    end else if (fr.is_data) begin
      flag_out <= frame_flag_in; // see [RULE4] [RULE5]
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      data_out <= '0;
    end else if (fr.is_data || fr.is_ctrl) begin
      data_out[`NARROW_W-1:0] <= frame_data_in[`NARROW_W-1:0];
      // upper bits are undefined in narrow mode; driven low to keep them quiet
      data_out[`DATA_W-1:`NARROW_W] <= word_width_select ?
        frame_data_in[`DATA_W-1:`NARROW_W] : '0; // see [RULE13]
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      link_ready_n_out <= 1'b1;
    end else if (frame_stb_in) begin
      link_ready_n_out <= !active_in; // see [RULE11] [RULE12]
    end
  end

  // ---------------- checks ----------------
  AST_INVALID_ERR: assert property (@(posedge mclk_in) disable iff (!rstn_in) // see [RULE1]
    (frame_stb_in && !kind_is_valid(frame_kind_in)) |=> (error_out && data_avail_n_out))
    else $error("invalid frame did not raise error");

  AST_ALT_ERR_OUT: assert property (@(posedge mclk_in) disable iff (!rstn_in) // see [RULE2]
    fr.err_alt |=> error_out ##1 (recovered_frame_strobe_out && error_out))
    else $error("alternation break not visible at the strobe");

  AST_FILL_KIND: assert property (@(posedge mclk_in) disable iff (!rstn_in) // see [RULE3]
    (frame_stb_in && kind_is_valid(frame_kind_in) && frame_kind_in != KIND_DATA
     && frame_kind_in != KIND_CTRL)
    |=> (data_avail_n_out && !control_avail_out && !error_out
         && fill_kind_out == kind_is_fill_one($past(frame_kind_in))))
    else $error("fill frame misreported");

  AST_FLAG_PASS: assert property (@(posedge mclk_in) disable iff (!rstn_in) // see [RULE4]
    (frame_stb_in && frame_kind_in == KIND_DATA && flag_mode_select)
    |=> (flag_out == $past(frame_flag_in) && !error_out))
    else $error("transparent flag bit not passed");

  AST_WIDTH16: assert property (@(posedge mclk_in) disable iff (!rstn_in) // see [RULE13]
    (frame_stb_in && frame_kind_in == KIND_DATA && !word_width_select)
    |=> (data_out[`DATA_W-1:`NARROW_W] == 4'h0
         && data_out[`NARROW_W-1:0] == $past(frame_data_in[`NARROW_W-1:0])))
    else $error("narrow mode data wrong");

  AST_DAV: assert property (@(posedge mclk_in) disable iff (!rstn_in) // see [RULE15]
    (frame_stb_in && frame_kind_in == KIND_DATA) |=> !data_avail_n_out ##1
    (recovered_frame_strobe_out && !data_avail_n_out))
    else $error("data frame not indicated at the strobe");

  AST_LINK_RDY: assert property (@(posedge mclk_in) disable iff (!rstn_in) // see [RULE11]
    frame_stb_in |=> (link_ready_n_out == !$past(active_in)))
    else $error("link ready not a retimed copy of active");

  AST_STROBE: assert property (@(posedge mclk_in) disable iff (!rstn_in) // see [RULE14]
    frame_stb_in |-> ##2 recovered_frame_strobe_out)
    else $error("recovered strobe missing two cycles after frame");

  AST_IRQ: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    (fr.err_invalid && irq_en_q[`IRQ_INVALID_BIT]) |=> irq_out [*2])
    else $error("enabled error event did not raise interrupt");

endmodule
`default_nettype wire

// *** bench/tx_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tx_model (
  input  wire logic        mclk_in,
  output logic             stb_out,
  output logic [2:0]       kind_out,
  output logic [19:0]      data_out,
  output logic             flag_out
);
  logic odd_q;
  logic sent_flag;

  initial begin
    odd_q     = 1'b0;
    sent_flag = 1'b0;
    stb_out   = 1'b0;
    kind_out  = 3'h7;
    data_out  = 20'h0;
    flag_out  = 1'b0;
  end

  // one frame per call; frames end up three cycles apart, above the two-cycle minimum
  task automatic send(input logic [2:0] kind, input logic [19:0] data,
                      input logic fmode, input logic uflag, input logic slip);
    @(posedge mclk_in);
    sent_flag = fmode ? uflag : odd_q;
    odd_q = (kind == 3'h0 && !fmode && !slip) ? ~odd_q : odd_q;
    stb_out  <= 1'b1;
    kind_out <= kind;
    data_out <= data;
    flag_out <= sent_flag;
    @(posedge mclk_in);
    // lines between frames must not keep showing the last frame
    stb_out  <= 1'b0;
    kind_out <= ~kind;
    data_out <= ~data;
    flag_out <= ~sent_flag;
  endtask
endmodule
`default_nettype wire

// *** bench/tb_serial_rx_frame_status.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rx_status_regs.svh"
module tb_serial_rx_frame_status;
  logic        mclk_in, rstn_in, psel, penable, pwrite, active, fdd, din, lin;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, f_stb, f_flag, flag_out, data_avail_n_out;
  logic [2:0]  f_kind;
  logic [19:0] f_data, data_out;
  logic        control_avail_out, fill_kind_out, error_out, link_ready_n_out;
  logic        recovered_frame_strobe_out, serial_data_out, equalizer_on_out;
  logic        freq_detector_on_out, phase_detector_on_out, irq_out;
  int          mismatches, n_checks;
  int unsigned seed;
  logic        fmode, loop, eq, wide, have_prev, prev_flag, e_flag, e_fill;
  logic [19:0] e_data;

  tx_model u_tx (.mclk_in(mclk_in), .stb_out(f_stb), .kind_out(f_kind),
                 .data_out(f_data), .flag_out(f_flag));

  serial_rx_frame_status u_dut (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .frame_stb_in(f_stb),
    .frame_kind_in(f_kind), .frame_data_in(f_data), .frame_flag_in(f_flag),
    .active_in(active), .freq_detect_disable_in(fdd), .din_in(din), .lin_in(lin),
    .data_out(data_out), .flag_out(flag_out), .data_avail_n_out(data_avail_n_out),
    .control_avail_out(control_avail_out), .fill_kind_out(fill_kind_out),
    .error_out(error_out), .link_ready_n_out(link_ready_n_out),
    .recovered_frame_strobe_out(recovered_frame_strobe_out),
    .serial_data_out(serial_data_out), .equalizer_on_out(equalizer_on_out),
    .freq_detector_on_out(freq_detector_on_out),
    .phase_detector_on_out(phase_detector_on_out), .irq_out(irq_out));

  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    tally_and_finish();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // the slave decides when to answer; only the bound stops a hung transfer
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge mclk_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge mclk_in);
    penable <= 1'b1;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready !== 1'b1);
    chk(32'(n), 32'h1, "apb answer");
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic exp_err(input logic [2:0] k, input logic f);
    return (k > 3'h4) || (k == 3'h0 && !fmode && have_prev && f == prev_flag);
  endfunction

  task automatic frame(input logic [2:0] k, input logic slip);
    logic [19:0] d;
    logic        act;
    logic        f;
    d   = 20'($urandom);
    act = 1'($urandom);
    active <= act;
    u_tx.send(k, d, fmode, 1'($urandom), slip);
    #1;
    f = u_tx.sent_flag;
    chk(error_out, exp_err(k, f), "error");
    chk(data_avail_n_out, k != 3'h0, "data_avail_n");
    chk(control_avail_out, k == 3'h1, "control_avail");
    chk(link_ready_n_out, !act, "link_ready_n");
    e_flag = (k == 3'h0) ? f : e_flag;
    e_data = (k <= 3'h1) ? (wide ? d : {4'h0, d[15:0]}) : e_data;
    e_fill = (k >= 3'h2 && k <= 3'h4) ? (k != 3'h2) : e_fill;
    prev_flag = (k == 3'h0) ? f : prev_flag;
    have_prev = have_prev | (k == 3'h0 && !fmode);
    chk(flag_out, e_flag, "flag");
    chk(data_out, e_data, "data");
    chk(fill_kind_out, e_fill, "fill_kind");
    @(posedge mclk_in);
    #1;
    chk(recovered_frame_strobe_out, 1'b1, "frame strobe");
  endtask

  task automatic chk_link();
    repeat (4) begin
      @(posedge mclk_in);
      din <= 1'($urandom);
      lin <= 1'($urandom);
      @(posedge mclk_in);
      #1;
      chk(serial_data_out, loop ? lin : din, "serial select");
      chk(equalizer_on_out, eq && !loop, "equalizer");
      chk(freq_detector_on_out, !fdd, "freq detector");
      chk(phase_detector_on_out, fdd, "phase detector");
    end
  endtask

  initial begin
    logic [31:0] rd;
    logic        er;
    logic [2:0]  k;
    seed = $urandom(32'h2c03);
    {rstn_in, psel, penable, pwrite, active, fdd, din, lin} = 8'h00;
    {fmode, loop, eq, wide, have_prev, prev_flag, e_flag, e_fill} = 8'h00;
    paddr  = 8'h00;
    pwdata = 32'h0;
    e_data = 20'h0;
    repeat (10) @(posedge mclk_in);
    rstn_in <= 1'b1;
    #1;
    chk({data_avail_n_out, link_ready_n_out, freq_detector_on_out}, 3'h7, "reset high");
    chk({error_out, irq_out, control_avail_out}, 3'h0, "reset low");
    apb(1'b0, `OFS_CTRL, 32'h0, rd, er);
    chk(rd, 32'h0, "ctrl reset");
    apb(1'b0, `OFS_IRQ_EN, 32'h0, rd, er);
    chk(rd, 32'h0, "irq enable reset");
    apb(1'b0, `OFS_IRQ_STAT, 32'h0, rd, er);
    chk(rd, 32'h0, "irq status reset");
    apb(1'b1, 8'h14, 32'hffff_ffff, rd, er);
    chk(er, 1'b1, "unmapped write");
    apb(1'b0, 8'h14, 32'h0, rd, er);
    chk({er, rd}, {1'b1, 32'h0}, "unmapped read");
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, `OFS_CTRL, 32'(c), rd, er);
      apb(1'b0, `OFS_CTRL, 32'h0, rd, er);
      chk(rd, 32'(c), "ctrl readback");
      // leaving flag mode restarts the alternation history
      have_prev = have_prev & !(fmode & !rd[`CTRL_FLAG_MODE_SELECT_BIT]);
      {wide, eq, loop, fmode} = rd[3:0];
      fdd <= 1'b0;
      frame(3'h2, 1'b0);
      frame(3'h3, 1'b0);
      chk_link();
      fdd <= 1'b1;
      chk_link();
      frame(3'h4, 1'b0);
      repeat (8) begin
        k = (($urandom % 3) == 0) ? 3'($urandom % 8) : 3'h0;
        frame(k, ($urandom % 5) == 0);
      end
    end
    for (int j = 0; j < 8; j++) begin
      frame(3'(j), 1'b0);
    end
    apb(1'b1, `OFS_IRQ_CLR, 32'hf, rd, er);
    apb(1'b1, `OFS_IRQ_EN, 32'h1, rd, er);
    frame(3'h6, 1'b0);
    repeat (2) @(posedge mclk_in);
    #1;
    chk(irq_out, 1'b1, "irq raised");
    apb(1'b0, `OFS_IRQ_STAT, 32'h0, rd, er);
    chk(rd[`IRQ_INVALID_BIT], 1'b1, "invalid sticky");
    apb(1'b1, `OFS_IRQ_EN, 32'h0, rd, er);
    repeat (2) @(posedge mclk_in);
    #1;
    chk(irq_out, 1'b0, "irq masked");
    apb(1'b1, `OFS_IRQ_CLR, 32'h1, rd, er);
    apb(1'b1, `OFS_IRQ_EN, 32'h1, rd, er);
    repeat (2) @(posedge mclk_in);
    #1;
    chk(irq_out, 1'b0, "irq cleared");
    apb(1'b0, `OFS_IRQ_STAT, 32'h0, rd, er);
    chk(rd[`IRQ_INVALID_BIT], 1'b0, "status cleared");
    apb(1'b0, `OFS_IRQ_CLR, 32'h0, rd, er);
    chk(rd, 32'h0, "clear reads zero");
    tally_and_finish();
  end
endmodule
`default_nettype wire
